// >>> pkg/bridge_cfg_pkg.sv
package bridge_cfg_pkg;

   // configuration-space byte offsets
   localparam logic [7:0] OFF_STATUS_LO = 8'h06;
   localparam logic [7:0] OFF_STATUS_HI = 8'h07;
   localparam logic [7:0] OFF_REVISION = 8'h08;
   localparam logic [7:0] OFF_CONTROL = 8'h40;

   // device status field positions within the 16-bit word
   localparam int STAT_MASTER_ABORT_BIT = 13;
   localparam int STAT_RCVD_TARGET_ABORT_BIT = 12;
   localparam int STAT_SIG_TARGET_ABORT_BIT = 11;
   localparam int STAT_SELECT_TIMING_LSB = 9;
   localparam logic [15:0] STATUS_RESET = 16'h0200;
   localparam logic [1:0] SELECT_TIMING_MEDIUM = 2'h1;

   // bridge control layout
   localparam int CTRL_PAGE_ALIAS_BIT = 6;
   localparam logic [7:0] CONTROL_RESET = 8'h20;
   localparam logic [7:0] CONTROL_WRITE_MASK = 8'h7F;

   // revision stepping, arbitrary value
   localparam logic [3:0] REVISION_STEPPING = 4'h1;

   // i/o decode of the reserved page registers
   localparam logic [15:0] PAGE_BASE_ADDR = 16'h0080;
   localparam logic [15:0] ALIAS_BASE_ADDR = 16'h0090;
   localparam logic [15:0] PORT92_ADDR = 16'h0092;

   // page register storage: sixteen page bytes plus port 92h
   localparam int PAGE_MEM_DEPTH = 32;
   localparam int PAGE_MEM_AW = 5;
   localparam logic [4:0] PORT92_INDEX = 5'h10;

   // i/o cycle phases
   typedef enum logic [0:0] {
      IO_IDLE = 1'b0,
      IO_DONE = 1'b1
   } io_phase_t;

endpackage

// >>> rtl/page_reg_mem.sv
module page_reg_mem
   import bridge_cfg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // write port
   input wire logic wr_en,
   input wire logic [PAGE_MEM_AW-1:0] wr_idx,
   input wire logic [7:0] wr_data,
   // read port
   input wire logic rd_en,
   input wire logic [PAGE_MEM_AW-1:0] rd_idx,
   output logic [7:0] rd_data_q
);

   logic [7:0] mem [PAGE_MEM_DEPTH];

   // storage array, no reset needed for data
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   // registered read data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data_q <= 8'h00;
      end else if (rd_en) begin
         rd_data_q <= mem[rd_idx];
      end
   end

endmodule

// >>> rtl/pci_bridge_status_control_cfg.sv
module pci_bridge_status_control_cfg
   import bridge_cfg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // configuration access, byte wide
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   output logic [7:0] cfg_rdata_q,
   output logic cfg_ack_q,
   // pci bus events, one-cycle pulses
   input wire logic master_abort_evt,
   input wire logic rcvd_target_abort_evt,
   input wire logic sig_target_abort_evt,
   // i/o cycle decode
   input wire logic io_req,
   input wire logic io_wr,
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   output logic io_ack_q,
   output logic io_claim_q,
   output logic io_fwd_q,
   output logic [7:0] io_rdata_q,
   // control view
   output logic page_alias_control_q
);

   // true when the address lies in the 16-byte window at base
   function automatic logic in_window(input logic [15:0] a, input logic [15:0] base);
      in_window = (a[15:4] == base[15:4]);
   endfunction

   logic master_abort_flag_q;
   logic received_target_abort_flag_q;
   logic signalled_target_abort_flag_q;
   logic [7:0] bridge_control_q;
   logic [7:0] cfg_rdata_d;
   logic [15:0] device_status;
   logic [7:0] revision_identifier;
   io_phase_t io_phase_q;

   // write decode and one-to-clear strobes
   wire wr_status_hi = cfg_wr && (cfg_addr == OFF_STATUS_HI);
   wire wr_control = cfg_wr && (cfg_addr == OFF_CONTROL);
   wire clr_master_abort = wr_status_hi && cfg_wdata[STAT_MASTER_ABORT_BIT-8];
   wire clr_rcvd_abort = wr_status_hi && cfg_wdata[STAT_RCVD_TARGET_ABORT_BIT-8];

   // sticky flags: an event in the clear cycle still sets
   wire master_abort_flag_d = master_abort_evt | (master_abort_flag_q & ~clr_master_abort);
   wire received_target_abort_flag_d = rcvd_target_abort_evt |
      (received_target_abort_flag_q & ~clr_rcvd_abort);
   wire signalled_target_abort_flag_d = sig_target_abort_evt | signalled_target_abort_flag_q;
   wire [7:0] bridge_control_d = wr_control ? (cfg_wdata & CONTROL_WRITE_MASK) : bridge_control_q;

   // status word: bit 15, bit 14 and bits 8:0 are constant zero
   assign device_status = {2'b00, master_abort_flag_q, received_target_abort_flag_q,
      signalled_target_abort_flag_q, SELECT_TIMING_MEDIUM, 9'h000};
   assign revision_identifier = {4'h0, REVISION_STEPPING};

   // configuration read mux, unmapped offsets read zero
   always_comb begin
      if (cfg_addr == OFF_STATUS_LO) begin
         cfg_rdata_d = device_status[7:0];
      end else if (cfg_addr == OFF_STATUS_HI) begin
         cfg_rdata_d = device_status[15:8];
      end else if (cfg_addr == OFF_REVISION) begin
         cfg_rdata_d = revision_identifier;
      end else if (cfg_addr == OFF_CONTROL) begin
         cfg_rdata_d = bridge_control_q;
      end else begin
         cfg_rdata_d = 8'h00;
      end
   end

   // status flags
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         master_abort_flag_q <= STATUS_RESET[STAT_MASTER_ABORT_BIT];
         received_target_abort_flag_q <= STATUS_RESET[STAT_RCVD_TARGET_ABORT_BIT];
         signalled_target_abort_flag_q <= STATUS_RESET[STAT_SIG_TARGET_ABORT_BIT];
      end else begin
         master_abort_flag_q <= master_abort_flag_d;
         received_target_abort_flag_q <= received_target_abort_flag_d;
         signalled_target_abort_flag_q <= signalled_target_abort_flag_d;
      end
   end

   // control register and configuration answer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bridge_control_q <= CONTROL_RESET;
         page_alias_control_q <= CONTROL_RESET[CTRL_PAGE_ALIAS_BIT];
         cfg_rdata_q <= 8'h00;
         cfg_ack_q <= 1'b0;
      end else begin
         bridge_control_q <= bridge_control_d;
         page_alias_control_q <= bridge_control_d[CTRL_PAGE_ALIAS_BIT];
         cfg_rdata_q <= cfg_rd ? cfg_rdata_d : cfg_rdata_q;
         cfg_ack_q <= cfg_rd | cfg_wr;
      end
   end

   // i/o decode of page registers, aliases and port 92h
   wire aliasing = ~bridge_control_q[CTRL_PAGE_ALIAS_BIT];
   wire hit_port92 = (io_addr == PORT92_ADDR);
   wire hit_low = in_window(io_addr, PAGE_BASE_ADDR);
   wire hit_high = in_window(io_addr, ALIAS_BASE_ADDR) && !hit_port92;
   wire hit_page = hit_low | (hit_high & aliasing);
   wire io_claim_d = io_req & (hit_page | hit_port92);
   wire io_fwd_d = io_req & ((hit_page & io_wr) | (hit_high & ~aliasing));
   wire [PAGE_MEM_AW-1:0] mem_idx = hit_port92 ? PORT92_INDEX : {1'b0, io_addr[3:0]};

   page_reg_mem u_page_mem (
      .clk(clk),
      .rst(rst),
      .wr_en(io_claim_d & io_wr),
      .wr_idx(mem_idx),
      .wr_data(io_wdata),
      .rd_en(io_claim_d & ~io_wr),
      .rd_idx(mem_idx),
      .rd_data_q(io_rdata_q)
   );

   // i/o answer, one cycle after the request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         io_phase_q <= IO_IDLE;
         io_ack_q <= 1'b0;
         io_claim_q <= 1'b0;
         io_fwd_q <= 1'b0;
      end else begin
         io_phase_q <= io_req ? IO_DONE : IO_IDLE;
         io_ack_q <= io_req;
         io_claim_q <= io_claim_d;
         io_fwd_q <= io_fwd_d;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_clear_ma;
      wr_status_hi && cfg_wdata[STAT_MASTER_ABORT_BIT-8] && !master_abort_evt;
   endsequence

   sequence s_read_status_hi;
      cfg_rd && (cfg_addr == OFF_STATUS_HI);
   endsequence

   sequence s_aliased_high;
      io_req && in_window(io_addr, ALIAS_BASE_ADDR) && (io_addr != PORT92_ADDR);
   endsequence

   a_master_abort_set: assert property (master_abort_evt |=> master_abort_flag_q)
      else $error("master abort flag not set");
   a_master_abort_clr: assert property (s_clear_ma |=> !master_abort_flag_q)
      else $error("master abort flag not cleared");
   a_rcvd_abort_wins: assert property (rcvd_target_abort_evt && clr_rcvd_abort |=> received_target_abort_flag_q)
      else $error("set lost against clear");
   a_rcvd_abort_hold: assert property (received_target_abort_flag_q && !clr_rcvd_abort
      |=> received_target_abort_flag_q) else $error("target abort flag dropped");
   a_sig_abort_sticky: assert property (signalled_target_abort_flag_q |=> signalled_target_abort_flag_q[*3])
      else $error("signalled abort flag cleared");
   a_status_hi_read: assert property (s_read_status_hi |=> cfg_ack_q && (cfg_rdata_q[7:6] == 2'b00) &&
      (cfg_rdata_q[2:1] == SELECT_TIMING_MEDIUM) && (cfg_rdata_q[5] == $past(master_abort_flag_q)))
      else $error("status high byte wrong");
   a_status_lo_zero: assert property (cfg_rd && cfg_addr == OFF_STATUS_LO |=> cfg_rdata_q == 8'h00)
      else $error("status low byte not zero");
   a_revision_read: assert property (cfg_rd && cfg_addr == OFF_REVISION |=> cfg_rdata_q[3:0] == REVISION_STEPPING)
      else $error("revision stepping wrong");
   a_control_msb: assert property (cfg_rd && cfg_addr == OFF_CONTROL |=> !cfg_rdata_q[7])
      else $error("control bit 7 not zero");
   a_alias_claim: assert property (s_aliased_high and aliasing |=> io_claim_q && (io_fwd_q == $past(io_wr)))
      else $error("aliased page access mishandled");
   a_alias_forward: assert property (s_aliased_high and !aliasing |=> !io_claim_q && io_fwd_q)
      else $error("high page access not forwarded");
   a_port92_claim: assert property (io_req && io_addr == PORT92_ADDR |=> io_claim_q && !io_fwd_q)
      else $error("port 92h not claimed");

   // further request shapes on both buses
   sequence s_read_ctrl;
      cfg_rd && (cfg_addr == OFF_CONTROL);
   endsequence

   sequence s_low_page;
      io_req && in_window(io_addr, PAGE_BASE_ADDR);
   endsequence

   sequence s_outside;
      io_req && !in_window(io_addr, PAGE_BASE_ADDR) && !in_window(io_addr, ALIAS_BASE_ADDR);
   endsequence

   sequence s_unmapped_read;
      cfg_rd && (cfg_addr != OFF_STATUS_LO) && (cfg_addr != OFF_STATUS_HI) &&
         (cfg_addr != OFF_REVISION) && (cfg_addr != OFF_CONTROL);
   endsequence

   // flags only rise on their own event
   a_master_abort_quiet: assert property (!master_abort_flag_q && !master_abort_evt |=> !master_abort_flag_q)
      else $error("master abort flag set without event");
   a_rcvd_abort_quiet: assert property (!received_target_abort_flag_q && !rcvd_target_abort_evt
      |=> !received_target_abort_flag_q) else $error("target abort flag set without event");
   a_sig_abort_quiet: assert property (!signalled_target_abort_flag_q && !sig_target_abort_evt
      |=> !signalled_target_abort_flag_q) else $error("signalled abort set without event");

   // setting events and write-one clears
   a_rcvd_abort_set: assert property (rcvd_target_abort_evt |=> received_target_abort_flag_q)
      else $error("target abort flag not set");
   a_rcvd_abort_clr: assert property (clr_rcvd_abort && !rcvd_target_abort_evt |=> !received_target_abort_flag_q)
      else $error("target abort flag not cleared");
   a_sig_abort_set: assert property (sig_target_abort_evt |=> signalled_target_abort_flag_q)
      else $error("signalled abort flag not set");
   a_master_abort_wins: assert property (master_abort_evt && clr_master_abort |=> master_abort_flag_q)
      else $error("master abort set lost against clear");
   a_master_abort_hold: assert property (master_abort_flag_q && !clr_master_abort |=> master_abort_flag_q)
      else $error("master abort flag dropped");

   // status high byte fields and unmapped offsets as read
   a_serr_zero: assert property (s_read_status_hi |=> !cfg_rdata_q[6])
      else $error("system error bit not zero");
   a_status_hi_edges: assert property (s_read_status_hi |=> !cfg_rdata_q[7] && !cfg_rdata_q[0])
      else $error("status reserved bits not zero");
   a_status_hi_flags: assert property (s_read_status_hi |=> (cfg_rdata_q[4] == $past(received_target_abort_flag_q))
      && (cfg_rdata_q[3] == $past(signalled_target_abort_flag_q)))
      else $error("status abort flags wrong");
   a_unmapped_zero: assert property (s_unmapped_read |=> cfg_rdata_q == 8'h00)
      else $error("unmapped offset not zero");

   // control register write and read back
   a_control_write: assert property (wr_control |=> bridge_control_q == ($past(cfg_wdata) & CONTROL_WRITE_MASK))
      else $error("control write lost");
   a_control_readback: assert property (s_read_ctrl |=> cfg_rdata_q == $past(bridge_control_q))
      else $error("control read back wrong");
   a_alias_copy: assert property (page_alias_control_q == bridge_control_q[CTRL_PAGE_ALIAS_BIT])
      else $error("alias control output stale");

   // configuration answer timing
   a_cfg_ack: assert property (cfg_rd || cfg_wr |=> cfg_ack_q)
      else $error("config access not acknowledged");
   a_cfg_idle: assert property (!cfg_rd && !cfg_wr |=> !cfg_ack_q)
      else $error("config ack without access");
   a_rdata_hold: assert property (!cfg_rd |=> $stable(cfg_rdata_q))
      else $error("config read data moved");

   // i/o decode outside the alias window
   a_low_claim: assert property (s_low_page |=> io_claim_q && (io_fwd_q == $past(io_wr)))
      else $error("low page access mishandled");
   a_outside_ignore: assert property (s_outside |=> !io_claim_q && !io_fwd_q)
      else $error("foreign i/o address claimed");

   // i/o answer timing and phase tracking
   a_io_ack: assert property (io_req |=> io_ack_q)
      else $error("i/o cycle not acknowledged");
   a_io_idle: assert property (!io_req |=> !io_ack_q && !io_claim_q && !io_fwd_q)
      else $error("i/o answer without request");
   a_io_phase: assert property (io_ack_q == (io_phase_q == IO_DONE))
      else $error("i/o phase and ack disagree");

endmodule

// >>> verification/pci_agent_model.sv
module pci_agent_model (
   // reset
   input wire logic rst,
   // event requests from the bench
   input wire logic [2:0] fire,
   // abort event pulses
   output logic master_abort_evt,
   output logic rcvd_target_abort_evt,
   output logic sig_target_abort_evt
);
   timeunit 1ns;
   timeprecision 1ps;
   // each bus outcome reaches the bridge as a one-cycle pulse
   assign master_abort_evt = fire[0] & ~rst;
   assign rcvd_target_abort_evt = fire[1] & ~rst;
   assign sig_target_abort_evt = fire[2] & ~rst;
endmodule

// >>> verification/pci_bridge_status_control_cfg_test.sv
module pci_bridge_status_control_cfg_test;
   timeunit 1ns;
   timeprecision 1ps;
   import bridge_cfg_pkg::*;
   logic clk, rst, cfg_rd, cfg_wr, io_req, io_wr, cfg_ack_q, io_ack_q, io_claim_q, io_fwd_q;
   logic master_abort_evt, rcvd_target_abort_evt, sig_target_abort_evt, page_alias_control_q;
   logic [7:0] cfg_addr, cfg_wdata, io_wdata, cfg_rdata_q, io_rdata_q, p92, d;
   logic [15:0] io_addr;
   logic [2:0] fire;
   int bad_count, comparisons, off;
   // device under test and bus agent
   pci_bridge_status_control_cfg u_pci_bridge_status_control_cfg (.clk, .rst, .cfg_rd, .cfg_wr,
      .cfg_addr, .cfg_wdata, .cfg_rdata_q, .cfg_ack_q, .master_abort_evt, .rcvd_target_abort_evt,
      .sig_target_abort_evt, .io_req, .io_wr, .io_addr, .io_wdata, .io_ack_q, .io_claim_q,
      .io_fwd_q, .io_rdata_q, .page_alias_control_q);
   pci_agent_model u_pci_agent_model (.rst, .fire, .master_abort_evt, .rcvd_target_abort_evt,
      .sig_target_abort_evt);
   // expected high status byte
   function automatic logic [7:0] exp_hi(input logic m, input logic r, input logic s);
      return {2'b00, m, r, s, SELECT_TIMING_MEDIUM, 1'b0};
   endfunction
   // compare one value
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one config access, optional event pulses alongside
   task automatic cfg(input logic wr, input logic [7:0] a, input logic [7:0] w, input logic [2:0] f);
      @(posedge clk);
      cfg_rd <= ~wr;
      cfg_wr <= wr;
      cfg_addr <= a;
      cfg_wdata <= w;
      fire <= f;
      @(posedge clk);
      cfg_rd <= 1'b0;
      cfg_wr <= 1'b0;
      fire <= 3'h0;
      #1 chk("cfg ack", 8'h01, {7'h00, cfg_ack_q});
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      cfg(1'b0, a, 8'h00, 3'h0);
      chk("cfg data", exp, cfg_rdata_q);
   endtask
   // one i/o cycle with expected claim and forward
   task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] w, input logic c, input logic fw);
      @(posedge clk);
      io_req <= 1'b1;
      io_wr <= wr;
      io_addr <= a;
      io_wdata <= w;
      @(posedge clk);
      io_req <= 1'b0;
      #1 chk("io ack", 8'h01, {7'h00, io_ack_q});
      chk("io claim", {7'h00, c}, {7'h00, io_claim_q});
      chk("io fwd", {7'h00, fw}, {7'h00, io_fwd_q});
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      report_and_stop();
   end
   // main sequence
   initial begin
      {rst, fire} = 4'h8;
      {cfg_rd, cfg_wr, io_req, io_wr, cfg_addr, cfg_wdata, io_wdata, io_addr} = '0;
      d = 8'($urandom(32'h0000_8d1f));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(OFF_STATUS_LO, 8'h00);
      rd(OFF_STATUS_HI, exp_hi(0, 0, 0));
      cfg(1'b0, OFF_REVISION, 8'h00, 3'h0);
      chk("stepping", {4'h0, REVISION_STEPPING}, cfg_rdata_q & 8'h0f);
      rd(OFF_CONTROL, CONTROL_RESET);
      rd(8'h41, 8'h00);
      cfg(1'b1, OFF_CONTROL, 8'hff, 3'h0);
      rd(OFF_CONTROL, 8'h7f);
      chk("alias ctl", 8'h01, {7'h00, page_alias_control_q});
      cfg(1'b1, OFF_CONTROL, 8'h20, 3'h0);
      // each abort event sets its own flag
      for (int i = 0; i < 3; i++) begin
         cfg(1'b1, 8'h41, 8'h00, 3'h1 << i);
         rd(OFF_STATUS_HI, exp_hi(1, i > 0, i > 1));
      end
      cfg(1'b1, OFF_STATUS_HI, 8'h00, 3'h0);
      rd(OFF_STATUS_HI, exp_hi(1, 1, 1));
      cfg(1'b1, OFF_STATUS_HI, 8'hff, 3'h1);
      rd(OFF_STATUS_HI, exp_hi(1, 0, 1));
      cfg(1'b1, OFF_STATUS_HI, 8'h10, 3'h2);
      rd(OFF_STATUS_HI, exp_hi(1, 1, 1));
      cfg(1'b1, OFF_STATUS_HI, 8'h30, 3'h0);
      rd(OFF_STATUS_HI, exp_hi(0, 0, 1));
      cfg(1'b1, OFF_STATUS_LO, 8'hff, 3'h0);
      rd(OFF_STATUS_LO, 8'h00);
      // random page traffic, aliasing on
      p92 = 8'($urandom);
      io(1'b1, PORT92_ADDR, p92, 1'b1, 1'b0);
      for (int n = 0; n < 12; n++) begin
         off = $urandom_range(15);
         d = 8'($urandom);
         io(1'b1, PAGE_BASE_ADDR + 16'(off), d, 1'b1, 1'b1);
         if (off != 2) begin
            io(1'b0, ALIAS_BASE_ADDR + 16'(off), 8'h00, 1'b1, 1'b0);
            chk("alias data", d, io_rdata_q);
         end
      end
      io(1'b0, PORT92_ADDR, 8'h00, 1'b1, 1'b0);
      chk("port92", p92, io_rdata_q);
      io(1'b0, 16'h00a0, 8'h00, 1'b0, 1'b0);
      io(1'b1, 16'h007f, 8'h00, 1'b0, 1'b0);
      // aliasing off
      cfg(1'b1, OFF_CONTROL, 8'h60, 3'h0);
      for (int n = 0; n < 16; n++) begin
         io(n[0], ALIAS_BASE_ADDR + 16'(n), 8'($urandom), n == 2, n != 2);
      end
      io(1'b0, PAGE_BASE_ADDR + 16'(off), 8'h00, 1'b1, 1'b0);
      chk("page data", d, io_rdata_q);
      io(1'b0, PORT92_ADDR, 8'h00, 1'b1, 1'b0);
      chk("port92", p92, io_rdata_q);
      report_and_stop();
   end
endmodule
